// file: tap_pkg.sv
// Purpose: Shared constants for the tap (pulse) event detector
// Assumes: Byte-wide register port, one clock
// Notes:   Offsets are the sensor register addresses
package tap_pkg;
    localparam logic [7:0] TAP_CFG_ADDR     = 8'h21;
    localparam logic [7:0] TAP_SRC_ADDR     = 8'h22;
    localparam logic [7:0] TAP_THS_X_ADDR   = 8'h23;
    localparam logic [7:0] TAP_THS_Y_ADDR   = 8'h24;
    localparam logic [7:0] TAP_THS_Z_ADDR   = 8'h25;
    localparam logic [7:0] TAP_TMLT_ADDR    = 8'h26;
    localparam logic [7:0] TAP_LTCY_ADDR    = 8'h27;
    localparam logic [7:0] CFG_RESET        = 8'h00;
    localparam logic [7:0] SRC_RESET        = 8'h00;
    localparam logic [7:0] THS_RESET        = 8'h00;
    localparam logic [7:0] TIME_RESET       = 8'h00;
    // Configuration field positions
    localparam int CFG_ABORT_BIT  = 7;
    localparam int CFG_LATCH_BIT  = 6;
    localparam int CFG_AXIS_BASE  = 0;   // Axis a: single at 2a, double at 2a+1
    // Source field positions
    localparam int SRC_ACTIVE_BIT = 7;
    localparam int SRC_AXIS_BASE  = 4;   // X,Y,Z at 4,5,6
    localparam int SRC_DOUBLE_BIT = 3;
    localparam int SRC_POL_BASE   = 0;   // X,Y,Z at 0,1,2
    localparam int AXES           = 3;
    localparam int THS_WIDTH      = 7;
    // Threshold scale 0.063g/LSB, fixed 8g range, in milli-g per step
    localparam int THS_MG_PER_LSB = 63;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FIRST,
        ST_LATENCY,
        ST_WINDOW,
        ST_SECOND,
        ST_HOLD
    } tap_state_t;
endpackage

// file: tap_pulse_event_detect.sv
// Purpose: Tap (single/double pulse) detection with config and source registers
// Assumes: Samples arrive as 14-bit signed words with a one-cycle sample strobe
// Notes:   Timers count in sample periods; second window equals the latency
module tap_pulse_event_detect #(
    parameter int SAMPLE_WIDTH = 14
) (
    input  wire logic                        mclk,
    input  wire logic                        reset_n,
    input  wire logic                        sample_valid,
    input  wire logic [3*SAMPLE_WIDTH-1:0]   sample_xyz,
    input  wire logic                        reg_write,
    input  wire logic                        reg_read,
    input  wire logic [7:0]                  reg_addr,
    input  wire logic [7:0]                  reg_wdata,
    output logic      [7:0]                  reg_rdata,
    output logic                             tap_event_active
);
    // Elaboration check: narrower samples cannot span the 8g threshold range
    if (SAMPLE_WIDTH < tap_pkg::THS_WIDTH + 4) begin : g_width_check
        $error("SAMPLE_WIDTH too small for the 8g threshold scale");
    end

    // Reset release synchroniser
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Threshold scale: full scale 8g spans the sample, 7-bit threshold lines up at the top
    localparam int SHIFT = SAMPLE_WIDTH - 1 - tap_pkg::THS_WIDTH;

    logic [7:0] cfg, next_cfg;
    logic [7:0] src, next_src;
    logic [6:0] ths [tap_pkg::AXES];
    logic [6:0] next_ths [tap_pkg::AXES];
    logic [7:0] tmlt, next_tmlt, ltcy, next_ltcy;
    logic [7:0] next_rdata;
    tap_pkg::tap_state_t state, next_state;
    logic [7:0] timer, next_timer;
    logic [2:0] axes_hit, next_axes_hit;
    logic [2:0] pol, next_pol;

    // Per-axis magnitude above threshold and sign
    logic [2:0] above;
    logic [2:0] negative;
    genvar g;
    generate
        for (g = 0; g < tap_pkg::AXES; g++) begin : g_axis
            logic signed [SAMPLE_WIDTH-1:0] s;
            logic        [SAMPLE_WIDTH-1:0] mag;
            assign s           = sample_xyz[g*SAMPLE_WIDTH +: SAMPLE_WIDTH];
            assign negative[g] = s[SAMPLE_WIDTH-1];
            assign mag         = negative[g] ? SAMPLE_WIDTH'(-s) : SAMPLE_WIDTH'(s);
            assign above[g]    = (mag >> SHIFT) > SAMPLE_WIDTH'(ths[g]);
        end
    endgenerate

    // Enable decode, used for single and double selection
    function automatic logic [2:0] axis_en(input logic [7:0] c, input logic dbl);
        logic [2:0] r;
        r = '0;
        for (int a = 0; a < tap_pkg::AXES; a++)
            r[a] = c[tap_pkg::CFG_AXIS_BASE + 2*a + int'(dbl)];
        return r;
    endfunction

    logic [2:0] sgl_en, dbl_en;
    logic       any_above;
    logic       src_read;
    assign sgl_en    = axis_en(cfg, 1'b0);
    assign dbl_en    = axis_en(cfg, 1'b1);
    assign any_above = |(above & (sgl_en | dbl_en));
    assign src_read  = reg_read && reg_addr == tap_pkg::TAP_SRC_ADDR;

    // Pulse detection sequence; advances only on sample strobes
    logic       fire;
    logic       fire_dbl;
    logic [2:0] fire_axes;
    always_comb begin
        next_state    = state;
        next_timer    = timer;
        next_axes_hit = axes_hit;
        next_pol      = pol;
        fire          = 1'b0;
        fire_dbl      = 1'b0;
        fire_axes     = '0;
        if (sample_valid) begin
            case (state)
                tap_pkg::ST_IDLE: begin
                    if (any_above) begin
                        next_state    = tap_pkg::ST_FIRST;
                        next_timer    = tmlt;
                        next_axes_hit = above & (sgl_en | dbl_en);
                        next_pol      = negative;
                    end
                end
                tap_pkg::ST_FIRST: begin
                    if (!any_above) begin
                        if (|(axes_hit & sgl_en)) begin
                            fire      = 1'b1;
                            fire_axes = axes_hit & sgl_en;
                        end
                        if (|(axes_hit & dbl_en)) begin
                            next_state = tap_pkg::ST_LATENCY;
                            next_timer = ltcy;
                        end else begin
                            next_state = tap_pkg::ST_IDLE;
                        end
                    end else if (timer == 8'h00) begin
                        next_state = tap_pkg::ST_HOLD; // Too long: not a tap
                    end else begin
                        next_timer = timer - 8'h01;
                    end
                end
                tap_pkg::ST_LATENCY: begin
                    // Starts ignored here unless the abort bit is set; abort watches starts only
                    // Latency spans ltcy samples; the expiry sample already opens the window
                    if (timer == 8'h00 && |(above & dbl_en)) begin
                        next_state    = tap_pkg::ST_SECOND;
                        next_timer    = tmlt;
                        next_axes_hit = above & dbl_en;
                        next_pol      = negative;
                    end else if (timer == 8'h00) begin
                        next_state = tap_pkg::ST_WINDOW;
                        next_timer = ltcy;
                    end else begin
                        next_timer = timer - 8'h01;
                        if (cfg[tap_pkg::CFG_ABORT_BIT] && any_above)
                            next_state = tap_pkg::ST_HOLD;
                    end
                    // Abort clear keeps counting through new starts
                end
                tap_pkg::ST_WINDOW: begin
                    if (|(above & dbl_en)) begin
                        next_state    = tap_pkg::ST_SECOND;
                        next_timer    = tmlt;
                        next_axes_hit = above & dbl_en;
                        next_pol      = negative;
                    end else if (timer == 8'h00) begin
                        next_state = tap_pkg::ST_IDLE;
                    end else begin
                        next_timer = timer - 8'h01;
                    end
                end
                tap_pkg::ST_SECOND: begin
                    if (!any_above) begin
                        fire       = 1'b1;
                        fire_dbl   = 1'b1;
                        fire_axes  = axes_hit & dbl_en;
                        next_state = tap_pkg::ST_IDLE;
                    end else if (timer == 8'h00) begin
                        next_state = tap_pkg::ST_HOLD;
                    end else begin
                        next_timer = timer - 8'h01;
                    end
                end
                tap_pkg::ST_HOLD: begin
                    // Suspended until acceleration falls back below threshold
                    if (!any_above)
                        next_state = tap_pkg::ST_IDLE;
                end
                default: next_state = tap_pkg::ST_IDLE;
            endcase
        end
    end

    // Source register update; a new event wins over a read clear
    always_comb begin
        next_src = src;
        if (src_read && cfg[tap_pkg::CFG_LATCH_BIT])
            next_src = tap_pkg::SRC_RESET;
        if (fire && !(cfg[tap_pkg::CFG_LATCH_BIT] && src[tap_pkg::SRC_ACTIVE_BIT]
                      && !src_read)) begin
            // Unlatched: later events overwrite
            next_src = tap_pkg::SRC_RESET;
            next_src[tap_pkg::SRC_ACTIVE_BIT] = 1'b1;
            for (int a = 0; a < tap_pkg::AXES; a++) begin
                next_src[tap_pkg::SRC_AXIS_BASE + a] = fire_axes[a];
                next_src[tap_pkg::SRC_POL_BASE + a]  = fire_axes[a] & pol[a];
            end
            next_src[tap_pkg::SRC_DOUBLE_BIT] = fire_dbl;
        end else if (!fire && !cfg[tap_pkg::CFG_LATCH_BIT] && src_read) begin
            next_src = tap_pkg::SRC_RESET;
        end
    end

    // Register writes and read data
    always_comb begin
        next_cfg  = cfg;
        next_ths  = ths;
        next_tmlt = tmlt;
        next_ltcy = ltcy;
        if (reg_write) begin
            case (reg_addr)
                tap_pkg::TAP_CFG_ADDR:   next_cfg    = reg_wdata;
                tap_pkg::TAP_THS_X_ADDR: next_ths[0] = reg_wdata[6:0];
                tap_pkg::TAP_THS_Y_ADDR: next_ths[1] = reg_wdata[6:0];
                tap_pkg::TAP_THS_Z_ADDR: next_ths[2] = reg_wdata[6:0];
                tap_pkg::TAP_TMLT_ADDR:  next_tmlt   = reg_wdata;
                tap_pkg::TAP_LTCY_ADDR:  next_ltcy   = reg_wdata;
                default: ;
            endcase
        end
        case (reg_addr)
            tap_pkg::TAP_CFG_ADDR:   next_rdata = cfg;
            tap_pkg::TAP_SRC_ADDR:   next_rdata = src;
            tap_pkg::TAP_THS_X_ADDR: next_rdata = {1'b0, ths[0]};
            tap_pkg::TAP_THS_Y_ADDR: next_rdata = {1'b0, ths[1]};
            tap_pkg::TAP_THS_Z_ADDR: next_rdata = {1'b0, ths[2]};
            tap_pkg::TAP_TMLT_ADDR:  next_rdata = tmlt;
            tap_pkg::TAP_LTCY_ADDR:  next_rdata = ltcy;
            default:                 next_rdata = 8'h00;
        endcase
    end

    // State registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg              <= tap_pkg::CFG_RESET;
            src              <= tap_pkg::SRC_RESET;
            ths              <= '{default: 7'h00};
            tmlt             <= tap_pkg::TIME_RESET;
            ltcy             <= tap_pkg::TIME_RESET;
            state            <= tap_pkg::ST_IDLE;
            timer            <= 8'h00;
            axes_hit         <= 3'h0;
            pol              <= 3'h0;
            reg_rdata        <= 8'h00;
            tap_event_active <= 1'b0;
        end else begin
            cfg              <= next_cfg;
            src              <= next_src;
            ths              <= next_ths;
            tmlt             <= next_tmlt;
            ltcy             <= next_ltcy;
            state            <= next_state;
            timer            <= next_timer;
            axes_hit         <= next_axes_hit;
            pol              <= next_pol;
            reg_rdata        <= next_rdata; // Data valid the cycle after the address
            tap_event_active <= next_src[tap_pkg::SRC_ACTIVE_BIT];
        end
    end
endmodule // tap_pulse_event_detect

// file: tap_event_checker_asserts.sv
// Purpose: Port-level checks for the tap event detector
// Assumes: One clock, read data registered one cycle after the address
// Notes:   Bound to every instance of the detector
module tap_event_checker #(
    parameter int SAMPLE_WIDTH = 14
) (
    input wire logic                      mclk,
    input wire logic                      reset_n,
    input wire logic                      sample_valid,
    input wire logic [3*SAMPLE_WIDTH-1:0] sample_xyz,
    input wire logic                      reg_write,
    input wire logic                      reg_read,
    input wire logic [7:0]                reg_addr,
    input wire logic [7:0]                reg_wdata,
    input wire logic [7:0]                reg_rdata,
    input wire logic                      tap_event_active
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // Register map and read path
    a_unmapped_reads_zero: assert property (
        (reg_addr < 8'h21 || reg_addr > 8'h27) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_cfg_write_readback: assert property (
        reg_write && reg_addr == 8'h21 ##1 reg_addr == 8'h21 && !reg_write
        |=> reg_rdata == $past(reg_wdata, 2)) else $error("config readback wrong");
    a_ths_seven_bit: assert property (
        reg_addr inside {[8'h23:8'h25]} |=> !reg_rdata[7]) else $error("threshold bit 7 set");
    // Source contents against the live flag
    a_active_mirror: assert property (
        reg_addr == 8'h22 |=> reg_rdata[7] == $past(tap_event_active))
        else $error("active flag and source differ");
    a_active_any_axis: assert property (
        reg_addr == 8'h22 |=> reg_rdata[7] == |reg_rdata[6:4]) else $error("active without axis");
    a_idle_src_clear: assert property (
        reg_addr == 8'h22 && !tap_event_active |=> reg_rdata[6:3] == 4'h0)
        else $error("idle source not clear");
    // Hold and clear; quiet sampling keeps a same-cycle event out of the way
    a_flag_holds: assert property (
        tap_event_active && !(reg_read && reg_addr == 8'h22) |=> tap_event_active)
        else $error("flag dropped without read");
    a_read_clears: assert property (
        reg_read && reg_addr == 8'h22 && !sample_valid && !$past(sample_valid)
        && !$past(sample_valid, 2) |=> !tap_event_active) else $error("read did not clear");
endmodule // tap_event_checker

bind tap_pulse_event_detect tap_event_checker #(.SAMPLE_WIDTH(SAMPLE_WIDTH)) tap_event_checker_inst (
    .mclk(mclk), .reset_n(reset_n), .sample_valid(sample_valid), .sample_xyz(sample_xyz),
    .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .tap_event_active(tap_event_active));

// file: tb_top.sv
// Purpose: Self-checking bench for the tap event detector
// Assumes: One sample every five clocks, thresholds of 16 steps
// Notes:   Register reads are checked by a queue monitor
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, reset_n, sample_valid, reg_write, reg_read, rd_d, tap_event_active;
    logic [41:0] sample_xyz;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, cfg;
    logic [7:0]  exp_q[$];
    int          n_mismatch, cmp_count;

    tap_pulse_event_detect tap_pulse_event_detect_inst (.mclk(mclk), .reset_n(reset_n),
        .sample_valid(sample_valid), .sample_xyz(sample_xyz), .reg_write(reg_write),
        .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .tap_event_active(tap_event_active));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Read data lands one clock after the strobe
    always @(posedge mclk) rd_d <= reg_read;
    always @(negedge mclk) begin
        if (rd_d === 1'b1) begin
            cmp_count++;
            if (reg_rdata !== exp_q[0]) begin
                n_mismatch++;
                $display("Error at %0t: got %h expected %h", $time, reg_rdata, exp_q[0]);
            end
            void'(exp_q.pop_front());
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
        reg_write = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk);
        reg_read = 1'b1;
        reg_addr = a;
        exp_q.push_back(e);
        @(negedge mclk);
        reg_read = 1'b0;
    endtask

    // Pattern bit i high puts sample i above threshold on one axis
    // All 16 samples run so a pending double window expires before the next test
    task automatic tap(input int ax, input bit ng, input logic [15:0] p);
        logic [13:0] v;
        for (int i = 0; i < 16; i++) begin
            v = p[i] ? 14'(1088 + $urandom % 3000) : 14'($urandom % 512);
            if (ng && p[i]) v = -v;
            @(negedge mclk);
            sample_valid = 1'b1;
            sample_xyz = {14'($urandom % 512), 14'($urandom % 512), 14'($urandom % 512)};
            sample_xyz[ax*14 +: 14] = v;
            @(negedge mclk);
            sample_valid = 1'b0;
            repeat (3) @(negedge mclk);
        end
        // Bounded wait, the read compare catches a missing flag
        for (int k = 0; k < 40 && tap_event_active !== 1'b1; k++) @(negedge mclk);
    endtask

    // Latched runs: the second read must find the source cleared
    task automatic run(input logic [7:0] c, input int ax, input bit ng,
                       input logic [15:0] p, input logic [7:0] e);
        wr(8'h21, c);
        tap(ax, ng, p);
        rd(8'h22, e);
        rd(8'h22, 8'h00);
        $display("Test cfg %h done", c);
    endtask

    task automatic final_report();
        $display("Compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Whole run is near 1140 clocks, so 100 us is a hang
    initial begin
        #100us;
        n_mismatch++;
        final_report();
    end

    initial begin
        {reset_n, sample_valid, reg_write, reg_read, sample_xyz} = '0;
        {reg_addr, reg_wdata, n_mismatch, cmp_count} = '0;
        void'($urandom(32'h78a2));
        repeat (5) @(negedge mclk);
        reset_n = 1'b1;
        repeat (4) @(negedge mclk);
        rd(8'h21, 8'h00);
        rd(8'h22, 8'h00);
        rd(8'h30, 8'h00);
        cfg = 8'($urandom);
        wr(8'h21, cfg);
        rd(8'h21, cfg);
        wr(8'h22, 8'hFF);
        rd(8'h22, 8'h00);
        for (int a = 8'h23; a <= 8'h25; a++) wr(8'(a), 8'h10);
        rd(8'h23, 8'h10);
        wr(8'h26, 8'h04);
        wr(8'h27, 8'h03);
        $display("Test registers done");
        run(8'h41, 0, 0, 16'h0001, 8'h90);
        run(8'h41, 1, 1, 16'h0001, 8'h00);
        run(8'h41, 0, 0, 16'h003F, 8'h00);
        run(8'h44, 1, 1, 16'h0001, 8'hA2);
        run(8'h50, 2, 1, 16'h0001, 8'hC4);
        run(8'h60, 2, 0, 16'h0001, 8'h00);
        run(8'h60, 2, 0, 16'h0021, 8'hC8);
        run(8'h60, 2, 0, 16'h0025, 8'hC8);
        run(8'hE0, 2, 0, 16'h0025, 8'h00);
        // Unlatched: the later pulse overwrites the polarity
        wr(8'h21, 8'h01);
        tap(0, 0, 16'h0001);
        tap(0, 1, 16'h0001);
        rd(8'h22, 8'h91);
        rd(8'h22, 8'h00);
        $display("Test unlatched done");
        repeat (3) @(negedge mclk);
        final_report();
    end
endmodule // tb_top
